// file: common/wakeup_watchdog_reset_map.vh
// Purpose: Timing constants for the wake-up, watchdog and reset supervisor.
// Assumes: System clock of 250 MHz; one tick of the shared time base is 1 us.
// Notes: Times are kept in their own unit; cycle counts are derived from them.
`ifndef WAKEUP_WATCHDOG_RESET_MAP_VH
`define WAKEUP_WATCHDOG_RESET_MAP_VH

// ---------------------------------------------------------------------------
// Clock and time base
// ---------------------------------------------------------------------------
`define CLK_MHZ 250
`define TICK_US 1
`define TICK_CYCLES (`CLK_MHZ * `TICK_US)

// ---------------------------------------------------------------------------
// Interval lengths in microseconds
// ---------------------------------------------------------------------------
`define WAKE_PERIOD_US 40000
`define RESET_DELAY_US 5000
`define FIRST_EDGE_US 20000
`define WAKE_PERIOD_TICKS (`WAKE_PERIOD_US / `TICK_US)
`define WAKE_HALF_TICKS (`WAKE_PERIOD_TICKS / 2)
`define RESET_DELAY_TICKS (`RESET_DELAY_US / `TICK_US)
`define FIRST_EDGE_TICKS (`FIRST_EDGE_US / `TICK_US)

// ---------------------------------------------------------------------------
// Kick input minimum level time, in nanoseconds
// ---------------------------------------------------------------------------
`define KICK_MIN_NS 5000
`define KICK_MIN_CYCLES ((`KICK_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: rtl/tick_divider.v
// Purpose: Divides the clock into a one-cycle tick enable for the time base.
// Assumes: DIV is at least 2.
// Notes: Restarts its count whenever restart is high.
`timescale 1ns/1ps
module tick_divider #(
  parameter DIV = 250
) (
  input wire clk,
  input wire rst,
  input wire restart,
  output reg tick
);
  reg [15:0] count;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (restart) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count == DIV[15:0] - 16'h0001) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // tick_divider

// file: rtl/wakeup_watchdog_reset.v
// Purpose: Wake-up square wave, watchdog kick check and active-low system reset.
// Assumes: kick_input and volt_good come from outside and are synchronised here.
// Notes: All intervals are counted in ticks of one shared time base.
`timescale 1ns/1ps
`include "wakeup_watchdog_reset_map.vh"
module wakeup_watchdog_reset #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter PERIOD_TICKS = `WAKE_PERIOD_TICKS,
  parameter HALF_TICKS = `WAKE_HALF_TICKS,
  parameter RESET_TICKS = `RESET_DELAY_TICKS,
  parameter FIRST_TICKS = `FIRST_EDGE_TICKS
) (
  input wire clk,
  input wire rst,
  input wire kick_input,
  input wire volt_good,
  output reg sys_reset_n,
  output reg wake_out
);
  // -------------------------------------------------------------------------
  // States
  // -------------------------------------------------------------------------
  localparam ST_HOLD = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_FIRST = 2'd2;
  localparam ST_RUN = 2'd3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [15:0] ticks;
  reg restart_count;
  reg kicked;
  reg kick_meta, kick_sync, kick_prev;
  reg good_meta, good_sync;
  wire tick;
  wire kick_fall;
  // Interval end strobes; each is high on the tick that closes its interval.
  wire delay_end;
  wire first_end;
  wire period_end;
  wire half_end;

  // -------------------------------------------------------------------------
  // Decoding
  // -------------------------------------------------------------------------
  // Returns high on the tick that closes an interval of the given length.
  function last_tick;
    input tick_now;
    input [15:0] count;
    input [15:0] length;
    begin
      last_tick = tick_now && (count == length - 16'h0001);
    end
  endfunction

  // All four intervals are taken from the same tick counter.
  assign delay_end = last_tick(tick, ticks, RESET_TICKS[15:0]);
  assign first_end = last_tick(tick, ticks, FIRST_TICKS[15:0]);
  assign period_end = last_tick(tick, ticks, PERIOD_TICKS[15:0]);
  assign half_end = last_tick(tick, ticks, HALF_TICKS[15:0]);

  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      kick_meta <= 1'b1;
      kick_sync <= 1'b1;
      kick_prev <= 1'b1;
      good_meta <= 1'b0;
      good_sync <= 1'b0;
    end else begin
      kick_meta <= kick_input;
      kick_sync <= kick_meta;
      kick_prev <= kick_sync;
      good_meta <= volt_good;
      good_sync <= good_meta;
    end
  end

  // The 5 us minimum level time of the processor needs no filter here.
  assign kick_fall = kick_prev & ~kick_sync;

  // -------------------------------------------------------------------------
  // Shared time base
  // -------------------------------------------------------------------------
  tick_divider #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .restart(restart_count),
    .tick(tick)
  );

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  always @* begin
    next_state = state;
    restart_count = 1'b0;
    case (state)
      ST_HOLD: begin
        if (good_sync) begin
          next_state = ST_DELAY;
          restart_count = 1'b1;
        end
      end
      ST_DELAY: begin
        if (!good_sync) begin
          next_state = ST_HOLD;
        end else if (delay_end) begin
          next_state = ST_FIRST;
          restart_count = 1'b1;
        end
      end
      ST_FIRST: begin
        if (!good_sync) begin
          next_state = ST_HOLD;
        end else if (first_end) begin
          next_state = ST_RUN;
          restart_count = 1'b1;
        end
      end
      ST_RUN: begin
        if (!good_sync) begin
          next_state = ST_HOLD;
        end else if (period_end && !kicked) begin
          next_state = ST_DELAY;
          restart_count = 1'b1;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_HOLD;
      ticks <= 16'h0000;
    end else begin
      state <= next_state;
      if (restart_count || next_state == ST_HOLD) begin
        ticks <= 16'h0000;
      end else if (tick) begin
        if (state == ST_RUN && period_end) begin
          ticks <= 16'h0000;
        end else begin
          ticks <= ticks + 16'h0001;
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Output registers
  // -------------------------------------------------------------------------
  // Outputs follow the next state so that they change on the same edge as the state.
  // A kick that lands on the period-end cycle is lost, since period_end is decoded ahead of kick_fall.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      kicked <= 1'b0;
      wake_out <= 1'b0;
      sys_reset_n <= 1'b0;
    end else begin
      // Reset output is low in the hold and delay states only.
      sys_reset_n <= (next_state == ST_FIRST) || (next_state == ST_RUN);
      if (next_state != ST_RUN) begin
        wake_out <= 1'b0;
        kicked <= 1'b0;
      end else if (state != ST_RUN) begin
        wake_out <= 1'b1;
        kicked <= 1'b0;
      end else if (period_end) begin
        wake_out <= 1'b1;
        kicked <= 1'b0;
      end else if (kick_fall && !kicked) begin
        wake_out <= 1'b0;
        kicked <= 1'b1;
      end else if (half_end) begin
        wake_out <= 1'b0;
      end
    end
  end
endmodule // wakeup_watchdog_reset

// file: verif/wakeup_watchdog_reset_sva.sv
// Purpose: Port timing checks of the wake-up, watchdog and reset supervisor.
// Assumes: Counts are ticks of TICK_CYCLES clocks.
// Notes: Windows allow one or two ticks of divider jitter.
`timescale 1ns/1ps
module wakeup_watchdog_reset_sva #(
  parameter TICK_CYCLES = 2,
  parameter PERIOD_TICKS = 40,
  parameter HALF_TICKS = 20,
  parameter RESET_TICKS = 5,
  parameter FIRST_TICKS = 20
) (
  input wire clk,
  input wire rst,
  input wire kick_input,
  input wire volt_good,
  input wire sys_reset_n,
  input wire wake_out
);
  localparam int T = TICK_CYCLES;
  localparam int P = PERIOD_TICKS * T;
  localparam int H = HALF_TICKS * T;
  localparam int R = RESET_TICKS * T;
  localparam int F = FIRST_TICKS * T;
  reg [15:0] up;
  reg [15:0] dn;
  reg [15:0] rc;
  reg seen;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      up <= 16'h0;
      dn <= 16'h0;
      rc <= 16'h0;
      seen <= 1'b0;
    end else begin
      up <= sys_reset_n ? up + {15'h0, ~&up} : 16'h0;
      dn <= (sys_reset_n || !volt_good) ? 16'h0 : dn + 16'h1;
      rc <= $rose(wake_out) ? 16'h1 : rc + {15'h0, ~&rc};
      seen <= !sys_reset_n ? 1'b0 : ($rose(wake_out) ? 1'b1 : seen);
    end
  end
  sequence kick_s;
    $fell(kick_input) && wake_out && sys_reset_n;
  endsequence
  first_rise_a: assert property ($rose(wake_out) && !seen |->
    up >= F - T - 2 && up <= F + T + 2) else $error("first wake rise off");
  period_a: assert property ($rose(wake_out) && seen |->
    rc >= P - 2 * T && rc <= P + 2 * T) else $error("wake period off");
  duty_a: assert property ($fell(wake_out) && sys_reset_n &&
    kick_input == $past(kick_input, 6) |-> rc >= H - 2 * T && rc <= H + 2 * T)
    else $error("wake high time off");
  kick_fall_a: assert property (kick_s |-> ##[1:6] !wake_out)
    else $error("kick did not lower wake");
  rst_wake_a: assert property (!sys_reset_n && $past(!sys_reset_n) |-> !wake_out)
    else $error("wake high in reset");
  rst_fall_a: assert property ($fell(sys_reset_n) |-> ##[0:1] !wake_out)
    else $error("wake late after reset");
  vg_low_a: assert property (!volt_good [*5] |-> !sys_reset_n)
    else $error("reset high on low voltage");
  vg_sync_a: assert property ($fell(volt_good) && sys_reset_n |=> sys_reset_n)
    else $error("voltage good used unsynced");
  release_a: assert property ($rose(sys_reset_n) |->
    dn >= R - T && dn <= R + 2 * T + 4) else $error("reset delay off");
endmodule // wakeup_watchdog_reset_sva
bind wakeup_watchdog_reset wakeup_watchdog_reset_sva #(.TICK_CYCLES(TICK_CYCLES),
  .PERIOD_TICKS(PERIOD_TICKS), .HALF_TICKS(HALF_TICKS), .RESET_TICKS(RESET_TICKS),
  .FIRST_TICKS(FIRST_TICKS)) u_sva (.clk(clk), .rst(rst), .kick_input(kick_input),
  .volt_good(volt_good), .sys_reset_n(sys_reset_n), .wake_out(wake_out));

// file: verif/uproc_model.sv
// Purpose: Processor that kicks dly cycles after each wake-up rise.
// Assumes: each kick holds the kick line low for 100 cycles.
// Notes: The kick line is a driven output that idles high.
`timescale 1ns/1ps
module uproc_model (
  input wire clk,
  input wire wake_out,
  input wire en,
  input wire [15:0] dly,
  output reg kick_input
);
  initial kick_input = 1'b1;
  always @(posedge wake_out) begin
    if (en) begin
      repeat (dly) @(posedge clk);
      #1 kick_input = 1'b0;
      repeat (100) @(posedge clk);
      #1 kick_input = 1'b1;
    end
  end
endmodule // uproc_model

// file: verif/wakeup_watchdog_reset_tb.sv
// Purpose: Self-checking bench of the supervisor with a kicking processor.
// Assumes: One tick is 20 clocks, so 5 ticks stand for the 5 us kick level.
// Notes: Intervals are counted in clocks from the previous event.
`timescale 1ns/1ps
module wakeup_watchdog_reset_tb;
  localparam int T = 20;
  localparam int P = 40 * T;
  localparam int H = 20 * T;
  localparam int R = 5 * T;
  localparam int F = 20 * T;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg volt_good = 1'b0;
  reg en = 1'b1;
  reg [15:0] dly = 16'h0005;
  wire kick_input;
  wire sys_reset_n;
  wire wake_out;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  int d;
  int e;
  always #2 clk = ~clk;
  wakeup_watchdog_reset #(.TICK_CYCLES(T), .PERIOD_TICKS(40), .HALF_TICKS(20),
    .RESET_TICKS(5), .FIRST_TICKS(20)) u_wakeup_watchdog_reset (.clk(clk), .rst(rst),
    .kick_input(kick_input), .volt_good(volt_good), .sys_reset_n(sys_reset_n),
    .wake_out(wake_out));
  uproc_model u_uproc_model (.clk(clk), .wake_out(wake_out), .en(en), .dly(dly),
    .kick_input(kick_input));
  task end_sim;
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input int got, input int exp, input int tol);
    cmp_count++;
    if (got < exp - tol || got > exp + tol) begin
      err_count++;
      $display("[ERR] %0t interval %0d expected %0d", $time, got, exp);
    end
  endtask
  task wt(input bit w, input logic lvl, output int k);
    k = 0;
    while ((w ? wake_out : sys_reset_n) !== lvl && k < 5000) begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  task restart;
    wt(0, 1'b1, n);
    chk(n, R + 2, T + 4);
    wt(1, 1'b1, n);
    chk(n, F, T + 2);
  endtask
  initial begin
    d = $urandom(4);
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat ($urandom_range(200, 50)) @(posedge clk);
    #1 wt(0, 1'b0, n);
    chk(n, 0, 0);
    volt_good = 1'b1;
    restart();
    for (int i = 0; i < 6; i++) begin
      e = (dly >= H) ? H : dly + 4;
      d = (i % 2 == 0) ? $urandom_range(590, 410) : $urandom_range(300, 5);
      dly = d[15:0];
      wt(1, 1'b0, n);
      chk(n, e, (e == H) ? T + 2 : 2);
      wt(1, 1'b1, n);
      chk(n, P - e, T + 2);
      wt(0, 1'b1, n);
      chk(n, 0, 0);
    end
    en = 1'b0;
    wt(1, 1'b0, n);
    wt(1, 1'b1, n);
    wt(1, 1'b0, n);
    chk(n, H, T + 2);
    wt(0, 1'b0, n);
    chk(n, P - H, T + 2);
    en = 1'b1;
    restart();
    repeat (10) @(posedge clk);
    #1 volt_good = 1'b0;
    wt(0, 1'b0, n);
    chk(n, 3, 1);
    wt(1, 1'b0, n);
    chk(n, 0, 1);
    repeat (30) @(posedge clk);
    #1 volt_good = 1'b1;
    restart();
    end_sim();
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule // wakeup_watchdog_reset_tb
